//--- acs_pkg.sv
// Shared constants, types and helpers for the conversion sequencer
package acs_pkg;

	// Clocking: SAR clock derived from the system clock
	localparam int SYS_CLK_MHZ = 100;
	localparam int SAR_CLK_MHZ = 25;
	localparam int SAR_DIV = SYS_CLK_MHZ / SAR_CLK_MHZ;

	// Converter widths
	localparam int RES_BITS = 10;
	localparam int ACC_W = 16;

	// Fixed tracking added by the track mode select, in SAR clocks
	localparam logic [7:0] TRACK4_TICKS = 8'h04;

	// Lowest converted bit index per resolution, and the MSB index
	localparam logic [3:0] LSB_IDX_10 = 4'h0;
	localparam logic [3:0] LSB_IDX_8 = 4'h2;
	localparam logic [3:0] MSB_IDX = 4'h9;

	// Start source select encodings
	localparam logic [1:0] SRC_SW = 2'h0;
	localparam logic [1:0] SRC_TIMER = 2'h1;
	localparam logic [1:0] SRC_PIN = 2'h2;

	// Reset values
	localparam logic [ACC_W-1:0] ACC_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PWRUP,
		ST_TRACK,
		ST_CONV
	} acs_state_e;

	typedef struct packed {
		logic [1:0] start_source_select;
		logic track_mode_select;
		logic burst_enable_bit;
		logic converter_on_bit;
		logic eight_bit_mode_bit;
		logic [4:0] powerup_delay_field;
		logic [5:0] burst_track_time_field;
		logic [2:0] repeat_sel;
	} acs_cfg_s;

	typedef struct packed {
		logic [7:0] result_high_byte;
		logic [7:0] result_low_byte;
	} acs_result_s;

	// Repeat select to number of conversions: 1,4,8,16,32,64
	function automatic logic [6:0] acs_rpt_count(input logic [2:0] sel);
		case (sel)
			3'h1: acs_rpt_count = 7'h04;
			3'h2: acs_rpt_count = 7'h08;
			3'h3: acs_rpt_count = 7'h10;
			3'h4: acs_rpt_count = 7'h20;
			3'h5: acs_rpt_count = 7'h40;
			default: acs_rpt_count = 7'h01;
		endcase
	endfunction : acs_rpt_count

endpackage : acs_pkg

//--- acs_pin_sync.sv
// Three-flop synchroniser with agreement check and rising edge detect
`timescale 1ns/100ps
`default_nettype none
module acs_pin_sync (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// Pin
	input wire logic i_pin,
	// Filtered level and edge
	output logic o_level,
	output logic o_rise
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;
	logic rise_q;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else if (i_ce) begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Level changes only once the last two stages agree
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			lvl_q <= 1'b0;
			rise_q <= 1'b0;
		end else if (i_ce) begin
			rise_q <= 1'b0;
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
				rise_q <= s3_q & ~lvl_q;
			end
		end
	end

	assign o_level = lvl_q;
	assign o_rise = rise_q;

endmodule : acs_pin_sync
`default_nettype wire

//--- acs_sequencer.sv
// Conversion sequencer: start sources, tracking, SAR, burst, results
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Function
// - Software busy write starts a conversion
// - Timer overflow starts a conversion
// - External pin rising edge starts a conversion
// - Completion posts result and sets done
// - Busy high during conversion, low after
// - Mode zero tracks continuously, converts at once
// - Mode one internal starts: four SAR clocks track
// - Pin with mode one: track while low
// - Burst from power down waits powerup delay
// - Burst already powered: first track by mode
// - Burst later conversions wait burst track time
// - Burst with mode one adds four clocks
// - Burst wakes, accumulates repeat samples, sleeps
// - Starts during a busy burst are ignored
// - Burst enable bit one selects burst
// - Converter on bit sets burst idle power
// - Burst: one start, repeat conversions
// - Done only after repeat count accumulated
// - Window compare only after full accumulation
// - Eight bit mode: low bits zero
module acs_sequencer
	import acs_pkg::*;
#(
	parameter int DIV = SAR_DIV
) (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// Configuration
	input wire acs_cfg_s i_cfg,
	input wire logic [ACC_W-1:0] i_win_hi,
	input wire logic [ACC_W-1:0] i_win_lo,
	// Start sources
	input wire logic i_busy_wr,
	input wire logic i_timer_ovf,
	input wire logic i_external_start_pin,
	// Software clear of flags
	input wire logic i_done_clr,
	// Analog converter side
	input wire logic i_cmp_above,
	output logic [RES_BITS-1:0] o_dac_code,
	output logic o_track,
	output logic o_power_on,
	// Status and result
	output logic o_conversion_busy_bit,
	output logic o_conversion_done_flag,
	output logic o_win_flag,
	output acs_result_s o_result
);
	//////////////////////////////////////////////////////////////////////////
	acs_state_e st_q;
	acs_state_e st_d;
	logic [7:0] wait_q;
	logic [7:0] wait_d;
	logic [7:0] div_q;
	logic tick;
	logic [RES_BITS-1:0] sar_q;
	logic [3:0] idx_q;
	logic [3:0] lsb_idx;
	logic [RES_BITS-1:0] trial_bit;
	logic [RES_BITS-1:0] conv_code;
	logic [6:0] cnt_q;
	logic [6:0] rpt;
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_next;
	logic pin_lvl;
	logic pin_rise;
	logic start_evt;
	logic accept;
	logic conv_end;
	logic post;
	logic load_conv;
	logic pwr_q;
	logic track_q;
	logic done_q;
	logic win_q;
	acs_result_s res_q;

	// Pin crosses into the clock domain; spacing rule keeps edges visible
	acs_pin_sync u_pin_sync (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_pin(i_external_start_pin),
		.o_level(pin_lvl),
		.o_rise(pin_rise)
	);

	//////////////////////////////////////////////////////////////////////////
	// SAR clock tick; stands in for the separate burst oscillator
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			div_q <= 8'h00;
		end else if (i_ce) begin
			if (div_q == 8'(DIV - 1)) begin
				div_q <= 8'h00;
			end else begin
				div_q <= div_q + 8'h01;
			end
		end
	end
	assign tick = (div_q == 8'(DIV - 1));

	//////////////////////////////////////////////////////////////////////////
	// Start decode
	always_comb begin
		case (i_cfg.start_source_select)
			SRC_SW: start_evt = i_busy_wr;
			SRC_TIMER: start_evt = i_timer_ovf;
			SRC_PIN: start_evt = pin_rise;
			default: start_evt = 1'b0;
		endcase
	end
	// Any start while busy is dropped, burst or not
	assign accept = start_evt && (st_q == ST_IDLE);

	assign rpt = acs_rpt_count(i_cfg.repeat_sel);
	assign lsb_idx = i_cfg.eight_bit_mode_bit ? LSB_IDX_8 : LSB_IDX_10;
	assign trial_bit = RES_BITS'(1) << idx_q;
	assign conv_code = sar_q | (i_cmp_above ? trial_bit : '0);
	assign acc_next = acc_q + ACC_W'(conv_code);
	assign conv_end = (st_q == ST_CONV) && tick && (idx_q == lsb_idx);
	assign post = conv_end && ((cnt_q + 7'h01) == rpt);

	//////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		st_d = st_q;
		wait_d = wait_q;
		load_conv = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (accept) begin
					if (i_cfg.burst_enable_bit && !pwr_q) begin
						st_d = ST_PWRUP;
						wait_d = 8'(i_cfg.powerup_delay_field) + 8'h01;
					end else if (i_cfg.track_mode_select &&
							(i_cfg.burst_enable_bit ||
							i_cfg.start_source_select != SRC_PIN)) begin
						st_d = ST_TRACK;
						wait_d = TRACK4_TICKS;
					end else begin
						st_d = ST_CONV;
						load_conv = 1'b1;
					end
				end
			end
			ST_PWRUP: begin
				if (tick && wait_q == 8'h01) begin
					if (i_cfg.track_mode_select) begin
						st_d = ST_TRACK;
						wait_d = TRACK4_TICKS;
					end else begin
						st_d = ST_CONV;
						load_conv = 1'b1;
					end
				end else if (tick) begin
					wait_d = wait_q - 8'h01;
				end
			end
			ST_TRACK: begin
				if (tick && wait_q == 8'h01) begin
					st_d = ST_CONV;
					load_conv = 1'b1;
				end else if (tick) begin
					wait_d = wait_q - 8'h01;
				end
			end
			ST_CONV: begin
				if (conv_end) begin
					if (post || !i_cfg.burst_enable_bit) begin
						st_d = ST_IDLE;
					end else begin
						st_d = ST_TRACK;
						wait_d = 8'(i_cfg.burst_track_time_field) + 8'h01 +
							(i_cfg.track_mode_select ? TRACK4_TICKS : 8'h00);
					end
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_q <= ST_IDLE;
			wait_q <= 8'h00;
		end else if (i_ce) begin
			st_q <= st_d;
			wait_q <= wait_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Successive approximation, MSB first
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sar_q <= '0;
			idx_q <= MSB_IDX;
		end else if (i_ce) begin
			if (load_conv) begin
				sar_q <= '0;
				idx_q <= MSB_IDX;
			end else if (st_q == ST_CONV && tick) begin
				sar_q <= conv_code;
				if (idx_q != lsb_idx) begin
					idx_q <= idx_q - 4'h1;
				end
			end
		end
	end
	// Eight-bit mode stops early, so bits 1:0 stay zero
	assign o_dac_code = (st_q == ST_CONV) ? (sar_q | trial_bit) : '0;

	//////////////////////////////////////////////////////////////////////////
	// Accumulation across the repeat count
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			acc_q <= ACC_RST;
			cnt_q <= 7'h00;
		end else if (i_ce) begin
			if (post) begin
				acc_q <= ACC_RST;
				cnt_q <= 7'h00;
			end else if (conv_end) begin
				acc_q <= acc_next;
				cnt_q <= cnt_q + 7'h01;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Result posting and flags; a new event beats a clear
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			res_q <= '{result_high_byte: BYTE_RST, result_low_byte: BYTE_RST};
		end else if (i_ce && post) begin
			if (i_cfg.eight_bit_mode_bit && rpt == 7'h01) begin
				res_q.result_high_byte <= conv_code[9:2];
				res_q.result_low_byte <= BYTE_RST;
			end else begin
				res_q <= acc_next;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			done_q <= 1'b0;
			win_q <= 1'b0;
		end else if (i_ce) begin
			done_q <= post | (done_q & ~i_done_clr);
			win_q <= (post && (acc_next > i_win_hi || acc_next < i_win_lo)) |
				(win_q & ~i_done_clr);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Power and track outputs
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pwr_q <= 1'b0;
			track_q <= 1'b0;
		end else if (i_ce) begin
			// Burst idle power follows the converter on bit
			pwr_q <= (st_d != ST_IDLE) | i_cfg.converter_on_bit;
			case (st_d)
				ST_TRACK: track_q <= 1'b1;
				ST_IDLE: begin
					if (i_cfg.burst_enable_bit) begin
						track_q <= i_cfg.converter_on_bit;
					end else if (!i_cfg.track_mode_select) begin
						track_q <= 1'b1;
					end else begin
						track_q <= (i_cfg.start_source_select == SRC_PIN) &&
							!pin_lvl;
					end
				end
				default: track_q <= 1'b0;
			endcase
		end
	end

	assign o_power_on = pwr_q;
	assign o_track = track_q;
	assign o_conversion_busy_bit = (st_q != ST_IDLE);
	assign o_conversion_done_flag = done_q;
	assign o_win_flag = win_q;
	assign o_result = res_q;

	//////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking acs_cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	sequence s_accept_idle;
		i_ce && st_q == ST_IDLE && start_evt;
	endsequence

	chk_sw_start: assert property (
		s_accept_idle and (i_cfg.start_source_select == SRC_SW && i_busy_wr)
		|=> o_conversion_busy_bit)
		else $error("software start not taken");

	chk_timer_start: assert property (
		i_ce && st_q == ST_IDLE && i_cfg.start_source_select == SRC_TIMER &&
		i_timer_ovf |=> o_conversion_busy_bit)
		else $error("timer start not taken");

	chk_pin_start: assert property (
		i_ce && st_q == ST_IDLE && i_cfg.start_source_select == SRC_PIN &&
		pin_rise |=> o_conversion_busy_bit)
		else $error("pin start not taken");

	chk_done_post: assert property (
		i_ce && post |=> o_conversion_done_flag && !o_conversion_busy_bit)
		else $error("done not posted at completion");

	chk_no_track: assert property (
		s_accept_idle and (!i_cfg.burst_enable_bit && !i_cfg.track_mode_select)
		|=> st_q == ST_CONV)
		else $error("conversion did not start at once");

	chk_track_four: assert property (
		s_accept_idle and (!i_cfg.burst_enable_bit && i_cfg.track_mode_select &&
		i_cfg.start_source_select != SRC_PIN)
		|=> st_q == ST_TRACK && wait_q == 8'h04)
		else $error("four clock tracking missing");

	chk_pwrup_wait: assert property (
		s_accept_idle and (i_cfg.burst_enable_bit && !pwr_q)
		|=> st_q == ST_PWRUP &&
		wait_q == 8'($past(i_cfg.powerup_delay_field)) + 8'h01)
		else $error("power-up delay not loaded");

	// A start taken mid-conversion would reload the SAR between ticks
	chk_busy_ignore: assert property (
		i_ce && st_q == ST_CONV && !tick && start_evt
		|=> $stable(idx_q) && $stable(sar_q))
		else $error("start during busy not ignored");

	chk_done_sticky: assert property (
		done_q && !i_done_clr |=> done_q)
		else $error("done flag dropped without clear");

	chk_eight_low: assert property (
		i_ce && post && i_cfg.eight_bit_mode_bit && rpt == 7'h01
		|=> o_result.result_low_byte == 8'h00)
		else $error("eight bit low byte not zero");

endmodule : acs_sequencer
`default_nettype wire

//--- acs_far_model.sv
// Far-side model: timer overflow, start pin and analog comparator
`timescale 1ns/100ps
`default_nettype none
module acs_far_model
	import acs_pkg::*;
(
	// Clock and commands from the bench
	input wire logic i_clk,
	input wire logic i_fire,
	input wire logic i_pin_lvl,
	input wire logic [RES_BITS-1:0] i_level,
	// Design side
	input wire logic [RES_BITS-1:0] i_dac_code,
	output logic o_timer_ovf,
	output logic o_pin,
	output logic o_cmp_above
);
	logic [2:0] gap_q = 3'h4;
	// Overflows kept at least five clocks apart
	always @(posedge i_clk) begin
		o_timer_ovf <= i_fire && gap_q == 3'h4;
		if (i_fire && gap_q == 3'h4)
			gap_q <= 3'h0;
		else if (gap_q != 3'h4)
			gap_q <= gap_q + 3'h1;
	end
	assign o_pin = i_pin_lvl;
	// Input sits half a code above i_level, so the SAR lands on it
	assign o_cmp_above = i_level >= i_dac_code;
endmodule : acs_far_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import acs_pkg::*;
;
	localparam int DV = 2;
	logic i_clk, rst, busy_wr, done_clr, fire, pin_lvl, tmr, pin, cmp, ce;
	logic busy, done, win, trk, pwr;
	logic [RES_BITS-1:0] lvl, dac;
	logic [ACC_W-1:0] whi, wlo;
	acs_cfg_s cfg;
	acs_result_s res;
	int failures = 0;
	int samples_checked = 0;
	int cyc = 0;
	int c0, c1;

	acs_sequencer #(.DIV(DV)) uut (.i_clk(i_clk), .i_sys_rst(rst),
		.i_ce(ce), .i_cfg(cfg), .i_win_hi(whi), .i_win_lo(wlo),
		.i_busy_wr(busy_wr), .i_timer_ovf(tmr), .i_external_start_pin(pin),
		.i_done_clr(done_clr), .i_cmp_above(cmp), .o_dac_code(dac),
		.o_track(trk), .o_power_on(pwr), .o_conversion_busy_bit(busy),
		.o_conversion_done_flag(done), .o_win_flag(win), .o_result(res));
	acs_far_model far (.i_clk(i_clk), .i_fire(fire), .i_pin_lvl(pin_lvl),
		.i_level(lvl), .i_dac_code(dac), .o_timer_ovf(tmr), .o_pin(pin),
		.o_cmp_above(cmp));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) cyc <= cyc + 1;

	//////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
		input string what);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	task automatic tick(input int n);
		repeat (n) @(negedge i_clk);
	endtask : tick

	task automatic clr;
		done_clr = 1'b1;
		tick(1);
		done_clr = 1'b0;
		tick(1);
	endtask : clr

	// Start from one source, count clocks until busy drops
	task automatic go(input logic [1:0] src, input bit poke, output int n);
		bit seen;
		int k;
		seen = 0;
		n = 0;
		if (src == 2'h2) begin
			pin_lvl = 1'b0;
			tick(8);
		end
		// Same divider phase each run, so timing differences are exact
		tick(1);
		repeat ((DV - cyc % DV) % DV)
			tick(1);
		case (src)
			2'h0: busy_wr = 1'b1;
			2'h1: fire = 1'b1;
			default: pin_lvl = 1'b1;
		endcase
		for (k = 0; k < 3000; k++) begin
			tick(1);
			// Poke lands between SAR ticks, mid-conversion
			busy_wr = poke && k == 5;
			fire = 1'b0;
			n++;
			if (k == 0 && src == 2'h0)
				chk(busy, 1'b1, "busy at start");
			if (done === 1'b1)
				break;
			if (busy === 1'b1)
				seen = 1;
			else if (seen)
				break;
		end
		if (k == 3000) begin
			failures++;
			end_sim;
		end
	endtask : go

	task automatic tend(input string s);
		$display("end of test %s", s);
	endtask : tend

	//////////////////////////////////////////////////////////////////////
	initial begin
		cfg = '0;
		whi = 16'hFFFF;
		wlo = 16'h0000;
		ce = 1'b1;
		busy_wr = 1'b0;
		done_clr = 1'b0;
		fire = 1'b0;
		pin_lvl = 1'b0;
		lvl = 10'h2A7;
		rst = 1'b1;
		tick(6);
		rst = 1'b0;
		tick(1);
		chk(busy, 1'b0, "busy idle");
		chk(done, 1'b0, "done idle");
		chk(trk, 1'b1, "track idle");
		go(2'h0, 0, c0);
		chk(res, 16'h02A7, "sw result");
		chk(done, 1'b1, "sw done");
		tick(5);
		chk(done, 1'b1, "done held");
		clr;
		chk(done, 1'b0, "done cleared");
		fire = 1'b1;
		tick(1);
		fire = 1'b0;
		tick(6);
		chk(busy, 1'b0, "unselected");
		// Two frozen edges keep the divider phase for DV of two
		ce = 1'b0;
		busy_wr = 1'b1;
		tick(1);
		busy_wr = 1'b0;
		tick(1);
		ce = 1'b1;
		tick(1);
		chk(busy, 1'b0, "frozen start");
		cfg.eight_bit_mode_bit = 1'b1;
		go(2'h0, 0, c1);
		chk(res, 16'hA900, "8-bit");
		chk(16'(c0 - c1), 16'(2 * DV), "8-bit time");
		clr;
		tend("software");
		cfg.eight_bit_mode_bit = 1'b0;
		cfg.start_source_select = SRC_TIMER;
		go(2'h1, 0, c0);
		chk(res, 16'h02A7, "timer result");
		clr;
		cfg.track_mode_select = 1'b1;
		go(2'h1, 0, c1);
		clr;
		chk(16'(c1 - c0), 16'(4 * DV), "track four");
		cfg.start_source_select = SRC_PIN;
		lvl = 10'h155;
		tick(1);
		chk(trk, 1'b1, "track pin low");
		go(2'h2, 0, c0);
		chk(res, 16'h0155, "pin result");
		chk(trk, 1'b0, "track pin high");
		clr;
		cfg.track_mode_select = 1'b0;
		go(2'h2, 0, c1);
		chk(16'(c1), 16'(c0), "pin track");
		clr;
		tend("hardware");
		cfg.start_source_select = SRC_SW;
		cfg.repeat_sel = 3'h1;
		lvl = 10'h100;
		wlo = 16'h0200;
		whi = 16'h0FFF;
		repeat (3) begin
			go(2'h0, 0, c0);
			chk(done, 1'b0, "done early");
		end
		go(2'h0, 0, c0);
		chk(done, 1'b1, "done fourth");
		chk(res, 16'h0400, "sum of four");
		chk(win, 1'b0, "window early");
		clr;
		whi = 16'h0100;
		wlo = 16'h0000;
		repeat (4) go(2'h0, 0, c0);
		chk(win, 1'b1, "window out");
		cfg.burst_enable_bit = 1'b1;
		cfg.converter_on_bit = 1'b1;
		whi = 16'hFFFF;
		clr;
		tend("repeat");
		go(2'h0, 1, c0);
		chk(res, 16'h0400, "burst sum");
		chk(done, 1'b1, "burst done");
		tick(3);
		chk(busy, 1'b0, "late start");
		chk(pwr, 1'b1, "idle power");
		clr;
		cfg.burst_track_time_field = 6'h03;
		go(2'h0, 0, c1);
		clr;
		chk(16'(c1 - c0), 16'(9 * DV), "burst track");
		cfg.burst_track_time_field = 6'h00;
		cfg.track_mode_select = 1'b1;
		go(2'h0, 0, c1);
		clr;
		chk(16'(c1 - c0), 16'(16 * DV), "burst track4");
		cfg.track_mode_select = 1'b0;
		cfg.converter_on_bit = 1'b0;
		cfg.powerup_delay_field = 5'h05;
		tick(3);
		go(2'h0, 0, c1);
		chk(16'(c1 - c0), 16'(6 * DV), "power-up wait");
		tick(2);
		chk(pwr, 1'b0, "powered down");
		tend("burst");
		end_sim;
	end
endmodule : tb_top
`default_nettype wire
